// ===== common/pdm_params.svh
// Timing constants and encodings for the dimming and pump-ratio control
`ifndef PDM_PARAMS_SVH
`define PDM_PARAMS_SVH

`define PDM_CLK_MHZ            50
`define PDM_SETUP_NS           10000
`define PDM_LO_MIN_NS          200
`define PDM_LO_MAX_NS          100000
`define PDM_HI_MIN_NS          200
`define PDM_SHDN_US            1500
`define PDM_SETTLE_US          40
`define PDM_STEP_DELAY_US      400
`define PDM_LO_MIN_CYC         ((`PDM_LO_MIN_NS * `PDM_CLK_MHZ + 999) / 1000)
`define PDM_LO_MAX_CYC         ((`PDM_LO_MAX_NS * `PDM_CLK_MHZ) / 1000)
`define PDM_SHDN_CYC           (`PDM_SHDN_US * `PDM_CLK_MHZ)
`define PDM_SETTLE_CYC         (`PDM_SETTLE_US * `PDM_CLK_MHZ)
`define PDM_STEP_DELAY_CYC     (`PDM_STEP_DELAY_US * `PDM_CLK_MHZ)
`define PDM_GAIN_FULL          3'h0
`define PDM_GAIN_LAST          3'h5
`define PDM_CHANNELS           3

`endif

// ===== common/pdm_pkg.sv
// Types for the dimming and pump-ratio control
package pdm_pkg;
   typedef enum logic [1:0] {
      PDM_RATIO_1X,
      PDM_RATIO_1P33X,
      PDM_RATIO_1P5X,
      PDM_RATIO_2X
   } pdm_ratio_type;

   typedef enum logic [1:0] {
      PDM_WIRE_OFF,
      PDM_WIRE_HIGH,
      PDM_WIRE_LOW
   } pdm_wire_type;
endpackage : pdm_pkg

// ===== design/pdm_ratio_seq.sv
// Charge-pump ratio sequencer driven by regulation-sense flags
`timescale 1ns/100ps
`default_nettype none
`include "pdm_params.svh"
module pdm_ratio_seq #(
   parameter int CHANNELS   = `PDM_CHANNELS,
   parameter int STEP_DELAY = `PDM_STEP_DELAY_CYC
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  run_i,
   input  wire logic [CHANNELS-1:0]   regulated_i,
   input  wire logic [CHANNELS-1:0]   open_i,
   input  wire logic                  supply_ok_1x_i,
   output var pdm_pkg::pdm_ratio_type ratio_o
);
   localparam int CW = $clog2(STEP_DELAY + 1);

   initial begin
      if (STEP_DELAY < 1 || CHANNELS < 1)
         $error("pdm_ratio_seq: bad parameters");
   end

   pdm_pkg::pdm_ratio_type ratio_r;
   logic [CW-1:0]          delay_r;
   logic                   lost;
   logic                   all_open;

   // Open channels take no part in the decision
   assign lost     = |(~regulated_i & ~open_i);
   assign all_open = &open_i;
   assign ratio_o  = ratio_r;

   // Count restarts after each step so the next ratio gets a full delay
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || !lost || supply_ok_1x_i) begin
         delay_r <= '0;
      end else if (delay_r == CW'(STEP_DELAY - 1)) begin
         delay_r <= '0;
      end else begin
         delay_r <= delay_r + CW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         ratio_r <= pdm_pkg::PDM_RATIO_1X;
      end else if (all_open) begin
         ratio_r <= pdm_pkg::PDM_RATIO_1X;
      end else if (ratio_r != pdm_pkg::PDM_RATIO_1X && supply_ok_1x_i) begin
         ratio_r <= pdm_pkg::PDM_RATIO_1X;
      end else if (lost && delay_r == CW'(STEP_DELAY - 1)) begin
         case (ratio_r)
            pdm_pkg::PDM_RATIO_1X:    ratio_r <= pdm_pkg::PDM_RATIO_1P33X;
            pdm_pkg::PDM_RATIO_1P33X: ratio_r <= pdm_pkg::PDM_RATIO_1P5X;
            pdm_pkg::PDM_RATIO_1P5X:  ratio_r <= pdm_pkg::PDM_RATIO_2X;
            default:                  ratio_r <= pdm_pkg::PDM_RATIO_2X;
         endcase
      end
   end
endmodule : pdm_ratio_seq
`default_nettype wire

// ===== design/pdm_control.sv
// Enable/dimming wire decoder, gain cycling and shutdown control
`timescale 1ns/100ps
`default_nettype none
`include "pdm_params.svh"
module pdm_control #(
   parameter int CHANNELS   = `PDM_CHANNELS,
   parameter int LO_MIN     = `PDM_LO_MIN_CYC,
   parameter int LO_MAX     = `PDM_LO_MAX_CYC,
   parameter int SHDN_LOW   = `PDM_SHDN_CYC,
   parameter int SETTLE     = `PDM_SETTLE_CYC,
   parameter int STEP_DELAY = `PDM_STEP_DELAY_CYC
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  enable_dim_wire_i,
   input  wire logic                  undervoltage_i,
   input  wire logic                  over_temp_i,
   input  wire logic                  supply_ok_1x_i,
   input  wire logic [CHANNELS-1:0]   regulated_i,
   input  wire logic [CHANNELS-1:0]   open_i,
   output logic                       enabled_o,
   output logic [2:0]                 gain_step_o,
   output logic                       gain_settling_o,
   output logic [CHANNELS-1:0]        led_sink_enable_o,
   output logic                       current_set_drive_o,
   output logic                       pump_run_o,
   output logic [1:0]                 pump_ratio_o
);
   localparam int LW = $clog2(SHDN_LOW + 1);
   localparam int SW = $clog2(SETTLE + 1);

   // Elaboration checks: the counters assume this ordering of the times
   initial begin
      if (CHANNELS < 1) begin
         $error("pdm_control: CHANNELS must be at least 1");
      end
      if (LO_MIN < 1) begin
         $error("pdm_control: LO_MIN must be at least 1");
      end
      if (LO_MAX <= LO_MIN) begin
         $error("pdm_control: LO_MAX must exceed LO_MIN");
      end
      if (SHDN_LOW <= LO_MAX) begin
         $error("pdm_control: SHDN_LOW must exceed LO_MAX");
      end
      if (SETTLE < 1) begin
         $error("pdm_control: SETTLE must be at least 1");
      end
      if (STEP_DELAY < 1) begin
         $error("pdm_control: STEP_DELAY must be at least 1");
      end
   end

   // Wire sampling
   logic                   wire_meta_r;
   logic                   wire_sync_r;
   logic                   wire_prev_r;

   // Wire decoding
   pdm_pkg::pdm_wire_type  wire_st_r;
   logic [LW-1:0]          low_cnt_r;
   logic                   pulse_ok_r;
   logic                   low_window;
   logic                   low_done;

   // Gain and settling
   logic [2:0]             gain_r;
   logic [SW-1:0]          settle_r;

   // Run control
   logic                   fault;
   logic                   rise;
   logic                   step;
   logic                   run;
   pdm_pkg::pdm_ratio_type ratio;

   assign fault = undervoltage_i | over_temp_i;
   assign rise  = wire_sync_r & ~wire_prev_r;
   assign run   = (wire_st_r != pdm_pkg::PDM_WIRE_OFF) & ~fault;

   // A low phase steps the gain only inside the program window
   assign low_window = (low_cnt_r >= LW'(LO_MIN - 1))
                    && (low_cnt_r <  LW'(LO_MAX));
   assign low_done   = (low_cnt_r == LW'(SHDN_LOW - 1));

   // Rising edge that ends a qualified low phase
   assign step = (wire_st_r == pdm_pkg::PDM_WIRE_LOW) & rise & pulse_ok_r;

   // First synchroniser stage; read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wire_meta_r <= 1'b0;
      end else begin
         wire_meta_r <= enable_dim_wire_i;
      end
   end

   // Second synchroniser stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wire_sync_r <= 1'b0;
      end else begin
         wire_sync_r <= wire_meta_r;
      end
   end

   // Delayed copy for edge detection; resets to the pulled-down idle level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wire_prev_r <= 1'b0;
      end else begin
         wire_prev_r <= wire_sync_r;
      end
   end

   // Low-phase length counter, saturating at the shutdown time
   always_ff @(posedge clk_i) begin
      if (rst_i || wire_sync_r) begin
         low_cnt_r <= '0;
      end else if (low_cnt_r != LW'(SHDN_LOW)) begin
         low_cnt_r <= low_cnt_r + LW'(1);
      end
   end

   // Qualification of the low phase, frozen while the wire is high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_ok_r <= 1'b0;
      end else if (!wire_sync_r) begin
         pulse_ok_r <= low_window;
      end
   end

   // Enable/shutdown state of the wire
   always_ff @(posedge clk_i) begin
      if (rst_i || fault) begin
         wire_st_r <= pdm_pkg::PDM_WIRE_OFF;
      end else begin
         case (wire_st_r)
            pdm_pkg::PDM_WIRE_OFF: begin
               if (wire_sync_r) begin
                  wire_st_r <= pdm_pkg::PDM_WIRE_HIGH;
               end
            end
            pdm_pkg::PDM_WIRE_HIGH: begin
               if (!wire_sync_r) begin
                  wire_st_r <= pdm_pkg::PDM_WIRE_LOW;
               end
            end
            pdm_pkg::PDM_WIRE_LOW: begin
               if (low_done) begin
                  wire_st_r <= pdm_pkg::PDM_WIRE_OFF;
               end else if (wire_sync_r) begin
                  wire_st_r <= pdm_pkg::PDM_WIRE_HIGH;
               end
            end
            default: begin
               wire_st_r <= pdm_pkg::PDM_WIRE_OFF;
            end
         endcase
      end
   end

   // Gain step: 0 is full scale, each step halves, wraps after the last
   always_ff @(posedge clk_i) begin
      if (rst_i || wire_st_r == pdm_pkg::PDM_WIRE_OFF) begin
         gain_r <= `PDM_GAIN_FULL;
      end else if (step) begin
         if (gain_r == `PDM_GAIN_LAST) begin
            gain_r <= `PDM_GAIN_FULL;
         end else begin
            gain_r <= gain_r + 3'h1;
         end
      end
   end

   // Settling window after each gain change
   always_ff @(posedge clk_i) begin
      if (rst_i || wire_st_r == pdm_pkg::PDM_WIRE_OFF) begin
         settle_r <= '0;
      end else if (step) begin
         settle_r <= SW'(SETTLE);
      end else if (settle_r != '0) begin
         settle_r <= settle_r - SW'(1);
      end
   end

   pdm_ratio_seq #(
      .CHANNELS   (CHANNELS),
      .STEP_DELAY (STEP_DELAY)
   ) u_ratio (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .run_i          (run),
      .regulated_i    (regulated_i),
      .open_i         (open_i),
      .supply_ok_1x_i (supply_ok_1x_i),
      .ratio_o        (ratio)
   );

   // Enable status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enabled_o <= 1'b0;
      end else begin
         enabled_o <= run;
      end
   end

   // Gain step seen by the current sinks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_step_o <= `PDM_GAIN_FULL;
      end else begin
         gain_step_o <= gain_r;
      end
   end

   // Settling status
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gain_settling_o <= 1'b0;
      end else begin
         gain_settling_o <= settle_r != '0;
      end
   end

   // Sinks are released in shutdown and on open channels
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_sink_enable_o <= '0;
      end else begin
         led_sink_enable_o <= {CHANNELS{run}} & ~open_i;
      end
   end

   // Current-set reference released in shutdown
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         current_set_drive_o <= 1'b0;
      end else begin
         current_set_drive_o <= run;
      end
   end

   // Charge pump runs only while enabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pump_run_o <= 1'b0;
      end else begin
         pump_run_o <= run;
      end
   end

   // Ratio shows 1x while off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pump_ratio_o <= 2'h0;
      end else if (run) begin
         pump_ratio_o <= ratio;
      end else begin
         pump_ratio_o <= 2'h0;
      end
   end
endmodule : pdm_control
`default_nettype wire

// ===== testbench/pdm_host_model.sv
// Host model that drives the enable and dimming wire
`timescale 1ns/100ps
`default_nettype none
module pdm_host_model (
   input  wire logic clk_i,
   output var  logic wire_o
);
   initial wire_o = 1'b0;
   task automatic hold(input logic lvl, input int n);
      @(posedge clk_i);
      #1 wire_o = lvl;
      repeat (n - 1) @(posedge clk_i);
      #1;
   endtask : hold
   // Callers keep the low phase inside the program window unless probing filtering
   task automatic pulse(input int lo, input int hi);
      hold(1'b0, lo);
      hold(1'b1, hi);
   endtask : pulse
   task automatic power_up(input int setup);
      hold(1'b1, setup);
   endtask : power_up
endmodule : pdm_host_model
`default_nettype wire

// ===== testbench/pdm_control_sva.sv
// Assertion checker for the dimming and pump-ratio control
`timescale 1ns/100ps
`default_nettype none
module pdm_control_sva #(
   parameter int SHDN_LOW = 75000
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       enable_dim_wire_i,
   input wire logic       undervoltage_i,
   input wire logic       over_temp_i,
   input wire logic       supply_ok_1x_i,
   input wire logic [2:0] regulated_i,
   input wire logic [2:0] open_i,
   input wire logic       enabled_o,
   input wire logic [2:0] gain_step_o,
   input wire logic       gain_settling_o,
   input wire logic [2:0] led_sink_enable_o,
   input wire logic       current_set_drive_o,
   input wire logic       pump_run_o,
   input wire logic [1:0] pump_ratio_o
);
   int lo_cnt_r;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Counts a continuous low on the wire, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || enable_dim_wire_i) begin
         lo_cnt_r <= 0;
      end else if (lo_cnt_r < SHDN_LOW + 8) begin
         lo_cnt_r <= lo_cnt_r + 1;
      end
   end
   property p_off; !enabled_o |-> !led_sink_enable_o && !current_set_drive_o && !pump_run_o
      && pump_ratio_o == 2'h0; endproperty
   a_off: assert property (p_off) else $error("outputs active while off");
   property p_shdn; lo_cnt_r == SHDN_LOW + 8 |-> !enabled_o; endproperty
   a_shdn: assert property (p_shdn) else $error("no shutdown on long low");
   property p_uv; undervoltage_i [*2] |-> !enabled_o; endproperty
   a_uv: assert property (p_uv) else $error("enabled in undervoltage");
   property p_ot; over_temp_i [*2] |-> !enabled_o; endproperty
   a_ot: assert property (p_ot) else $error("enabled in over-temperature");
   property p_en; ($rose(enable_dim_wire_i) && !enabled_o) ##0 (enable_dim_wire_i
      && !undervoltage_i && !over_temp_i) [*4] |=> enabled_o && gain_step_o == 3'h0; endproperty
   a_en: assert property (p_en) else $error("no enable at full gain");
   property p_gain; $changed(gain_step_o) && enabled_o && $past(enabled_o) |->
      gain_step_o == ($past(gain_step_o) == 3'h5 ? 3'h0 : $past(gain_step_o) + 3'h1); endproperty
   a_gain: assert property (p_gain) else $error("bad gain step");
   property p_settle; $changed(gain_step_o) && enabled_o |-> gain_settling_o; endproperty
   a_settle: assert property (p_settle) else $error("settling not flagged");
   property p_ratio; $changed(pump_ratio_o) |->
      pump_ratio_o == 2'h0 || pump_ratio_o == $past(pump_ratio_o) + 2'h1; endproperty
   a_ratio: assert property (p_ratio) else $error("ratio skipped a step");
   property p_back; supply_ok_1x_i [*4] |-> pump_ratio_o == 2'h0; endproperty
   a_back: assert property (p_back) else $error("ratio not back to 1x");
   property p_open; (open_i == 3'h7) [*4] |-> pump_ratio_o == 2'h0; endproperty
   a_open: assert property (p_open) else $error("all open not in 1x");
   c_wrap: cover property ($past(gain_step_o) == 3'h5 && gain_step_o == 3'h0);
   c_top: cover property (pump_ratio_o == 2'h3);
   c_down: cover property ($fell(enabled_o));
endmodule : pdm_control_sva
bind pdm_control pdm_control_sva #(.SHDN_LOW(SHDN_LOW)) pdm_control_sva_i (.*);
`default_nettype wire

// ===== testbench/pdm_control_tb.sv
// Testbench for the dimming and pump-ratio control
`timescale 1ns/100ps
`default_nettype none
module pdm_control_tb;
   localparam int LO_MIN = 10;
   localparam int LO_MAX = 100;
   localparam int SHDN = 400;
   localparam int STEP = 50;
   localparam int SETUP = 500;
   logic       clk_i;
   logic       rst_i;
   logic       wire_w;
   logic       uv;
   logic       ot;
   logic       ok1x;
   logic [2:0] regd;
   logic [2:0] opn;
   logic       en;
   logic [2:0] gain;
   logic       settle;
   logic [2:0] sinks;
   logic       drive;
   logic [1:0] ratio;
   logic       prun;
   int         n_errors = 0;
   int         tests_run = 0;
   pdm_host_model pdm_host_model_i (.clk_i(clk_i), .wire_o(wire_w));
   pdm_control #(.LO_MIN(LO_MIN), .LO_MAX(LO_MAX), .SHDN_LOW(SHDN), .SETTLE(20),
      .STEP_DELAY(STEP)) pdm_control_i (.clk_i(clk_i), .rst_i(rst_i),
      .enable_dim_wire_i(wire_w), .undervoltage_i(uv), .over_temp_i(ot),
      .supply_ok_1x_i(ok1x), .regulated_i(regd), .open_i(opn), .enabled_o(en),
      .gain_step_o(gain), .gain_settling_o(settle), .led_sink_enable_o(sinks),
      .current_set_drive_o(drive), .pump_run_o(prun), .pump_ratio_o(ratio));
   initial clk_i = 1'b0;
   always #10 clk_i = ~clk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cyc
   task automatic t_enable;
      pdm_host_model_i.power_up(SETUP);
      chk(8'(en), 8'h01);
      chk(8'(gain), 8'h00);
      chk(8'(sinks), 8'h07);
      chk(8'(drive), 8'h01);
      chk(8'(prun), 8'h01);
      chk(8'(ratio), 8'h00);
      $display("t_enable done");
   endtask : t_enable
   task automatic t_dim;
      for (int i = 1; i <= 7; i++) begin
         pdm_host_model_i.pulse(LO_MIN, 8);
         chk(8'(gain), 8'(i % 6));
         chk(8'(settle), 8'h01);
      end
      pdm_host_model_i.pulse(3, 8);
      chk(8'(gain), 8'h01);
      pdm_host_model_i.pulse(LO_MAX + 10, 8);
      chk(8'(gain), 8'h01);
      chk(8'(en), 8'h01);
      chk(8'(settle), 8'h00);
      $display("t_dim done");
   endtask : t_dim
   task automatic t_shdn;
      pdm_host_model_i.hold(1'b0, SHDN + 10);
      chk(8'(en), 8'h00);
      chk(8'(sinks), 8'h00);
      chk(8'(drive), 8'h00);
      chk(8'(prun), 8'h00);
      pdm_host_model_i.power_up(SETUP);
      chk(8'(gain), 8'h00);
      $display("t_shdn done");
   endtask : t_shdn
   task automatic t_ratio;
      regd = 3'h6;
      for (int m = 1; m <= 4; m++) begin
         cyc(STEP + 10);
         chk(8'(ratio), 8'(m > 3 ? 3 : m));
      end
      ok1x = 1'b1;
      cyc(6);
      chk(8'(ratio), 8'h00);
      ok1x = 1'b0;
      cyc(STEP - 10);
      regd = 3'h7;
      cyc(2);
      regd = 3'h3;
      cyc(STEP - 10);
      chk(8'(ratio), 8'h00);
      opn = 3'h4;
      cyc(STEP + 10);
      chk(8'(ratio), 8'h00);
      chk(8'(sinks), 8'h03);
      opn = 3'h7;
      regd = 3'h0;
      cyc(STEP + 10);
      chk(8'(ratio), 8'h00);
      chk(8'(sinks), 8'h00);
      opn = 3'h0;
      regd = 3'h7;
      $display("t_ratio done");
   endtask : t_ratio
   task automatic t_fault;
      ot = 1'b1;
      cyc(3);
      chk(8'(en), 8'h00);
      ot = 1'b0;
      cyc(8);
      chk(8'(en), 8'h01);
      uv = 1'b1;
      cyc(3);
      chk(8'(en), 8'h00);
      chk(8'(sinks), 8'h00);
      chk(8'(prun), 8'h00);
      $display("t_fault done");
   endtask : t_fault
   task automatic end_of_test;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #200000;
      n_errors++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      rst_i = 1'b1;
      uv = 1'b0;
      ot = 1'b0;
      ok1x = 1'b0;
      regd = 3'h7;
      opn = 3'h0;
      repeat (4) @(posedge clk_i);
      #1 rst_i = 1'b0;
      t_enable();
      t_dim();
      t_shdn();
      t_ratio();
      t_fault();
      end_of_test();
   end
endmodule : pdm_control_tb
`default_nettype wire
